// ===== rtl/tpg_regs.svh
// Register indices, field positions, reset values for the three-port GPIO.
// Assumes APB byte address = 4 * index; included by tpg_pkg and tpg_top.
//
// Operation
// - Second-port direction bit 1 releases the pin as an input.
// - Second-port direction bit 0 drives the output latch onto the pin.
// - Third-port direction 1 releases the pin, 0 drives the latch value.
// - Option bit 7 cleared enables weak pull-ups on second-port pins set as inputs.
// - Pull-up of a second-port pin set as output is always off.
// - Option register resets to all ones, pull-ups disabled.
// - Only second-port pins 7..4 set as inputs take part in change detection.
// - Each such pin is compared against the value captured at the last access.
// - Mismatches are ORed and set the change flag, bit 0 of interrupt control.
// - A port-change interrupt can wake the device from sleep.
// - Any read or write of second-port data refreshes the reference.
// - The flag keeps setting while mismatch lasts; software ends it, then clears.
// - Second-port bit 0 is an external interrupt with edge chosen by option bit 6.
// - An enabled peripheral overrides a third-port pin direction and value.
// - Unimplemented register bits read as zero.
// - Direction registers reset to all ones: every pin an input.
// - Analog field sits in bits 2..0 of its register and resets to zero.
// - Port data read returns pin levels; write updates the output latch.
// - After reset first-port analog pins are analog and read as zero.
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH

`define TPG_IDX_FIRST_DATA 10'h005
`define TPG_IDX_SECOND_DATA 10'h006
`define TPG_IDX_SECOND_DATA_M 10'h106
`define TPG_IDX_THIRD_DATA 10'h007
`define TPG_IDX_INTC 10'h00B
`define TPG_IDX_INTC_M1 10'h08B
`define TPG_IDX_INTC_M2 10'h10B
`define TPG_IDX_INTC_M3 10'h18B
`define TPG_IDX_OPTION 10'h081
`define TPG_IDX_OPTION_M 10'h181
`define TPG_IDX_FIRST_DIR 10'h085
`define TPG_IDX_SECOND_DIR 10'h086
`define TPG_IDX_SECOND_DIR_M 10'h186
`define TPG_IDX_THIRD_DIR 10'h087
`define TPG_IDX_ANALOG_CFG 10'h09F

`define TPG_OPT_PULLUP_N 7
`define TPG_OPT_EDGE_SEL 6
`define TPG_INTC_CHG_FLAG 0
`define TPG_INTC_EXT_FLAG 1
`define TPG_INTC_CHG_EN 3
`define TPG_INTC_EXT_EN 4

`define TPG_RST_OPTION 8'hFF
`define TPG_RST_FIRST_DIR 6'h3F
`define TPG_RST_DIR8 8'hFF
`define TPG_RST_ANALOG_CFG 3'h0
`define TPG_RST_INTC 8'h00
`define TPG_OPEN_DRAIN_BIT 4

`endif

// ===== rtl/tpg_pkg.sv
// Types of the three-port GPIO block.
// Assumes tpg_regs.svh is on the include path.
`include "tpg_regs.svh"

package tpg_pkg;

    typedef enum logic [3:0] {
        TPG_SEL_NONE = 4'h0,
        TPG_SEL_FIRST_DATA = 4'h1,
        TPG_SEL_SECOND_DATA = 4'h3,
        TPG_SEL_THIRD_DATA = 4'h2,
        TPG_SEL_INTC = 4'h6,
        TPG_SEL_OPTION = 4'h7,
        TPG_SEL_FIRST_DIR = 4'h5,
        TPG_SEL_SECOND_DIR = 4'h4,
        TPG_SEL_THIRD_DIR = 4'hC,
        TPG_SEL_ANALOG_CFG = 4'hD
    } tpg_sel_t;

    typedef struct packed {
        logic [7:0] option;
        logic [5:0] first_dir;
        logic [7:0] second_dir;
        logic [7:0] third_dir;
        logic [5:0] first_lat;
        logic [7:0] second_lat;
        logic [7:0] third_lat;
        logic [2:0] analog_cfg;
        logic [7:0] intc;
        logic [3:0] chg_ref;
        logic ext_prev;
        logic [5:0] first_out;
        logic [5:0] first_oe;
        logic [7:0] second_out;
        logic [7:0] second_oe;
        logic [7:0] second_pullup;
        logic [7:0] third_out;
        logic [7:0] third_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic wake;
    } tpg_state_t;

endpackage

// ===== rtl/tpg_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
`default_nettype none

module tpg_sync #(
    parameter int W = 22
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) $error("tpg_sync: width must be at least 1");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/tpg_top.sv
// Three bidirectional ports with pull-ups, change detect and edge interrupt.
// Assumes an APB master on pclk, pins and on-chip peripherals outside.
`timescale 1ns/1ps
`default_nettype none
`include "tpg_regs.svh"

module tpg_top #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] first_port_in,
    output logic [5:0] first_port_out,
    output logic [5:0] first_port_oe,
    input wire logic [7:0] second_port_in,
    output logic [7:0] second_port_out,
    output logic [7:0] second_port_oe,
    output logic [7:0] second_port_pullup,
    input wire logic [7:0] third_port_in,
    output logic [7:0] third_port_out,
    output logic [7:0] third_port_oe,
    input wire logic [7:0] periph_en,
    input wire logic [7:0] periph_dir,
    input wire logic [7:0] periph_out,
    output logic [2:0] analog_config_field,
    output logic wake_req
);
    import tpg_pkg::*;

    // ==========================================================
    // Elaboration check
    // ==========================================================
    initial begin
        if (ADDR_W < 11 || ADDR_W > 32) begin
            $error("tpg_top: ADDR_W must lie in 11..32");
        end
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [21:0] pins_s;
    logic [5:0] first_s;
    logic [7:0] second_s;
    logic [7:0] third_s;

    tpg_sync #(
        .W(22)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({third_port_in, second_port_in, first_port_in}),
        .q(pins_s)
    );

    assign first_s = pins_s[5:0];
    assign second_s = pins_s[13:6];
    assign third_s = pins_s[21:14];

    // ==========================================================
    // Address decode
    // ==========================================================
    logic [9:0] idx;
    tpg_sel_t sel;

    assign idx = paddr[11:2];

    // Mirrors decode to the same selector
    always_comb begin
        if (paddr[1:0] != 2'h0 || (ADDR_W > 12 && |(paddr >> 12))) begin
            sel = TPG_SEL_NONE;
        end else if (idx == `TPG_IDX_FIRST_DATA) begin
            sel = TPG_SEL_FIRST_DATA;
        end else if (idx == `TPG_IDX_SECOND_DATA
                     || idx == `TPG_IDX_SECOND_DATA_M) begin
            sel = TPG_SEL_SECOND_DATA;
        end else if (idx == `TPG_IDX_THIRD_DATA) begin
            sel = TPG_SEL_THIRD_DATA;
        end else if (idx == `TPG_IDX_INTC || idx == `TPG_IDX_INTC_M1
                     || idx == `TPG_IDX_INTC_M2 || idx == `TPG_IDX_INTC_M3) begin
            sel = TPG_SEL_INTC;
        end else if (idx == `TPG_IDX_OPTION || idx == `TPG_IDX_OPTION_M) begin
            sel = TPG_SEL_OPTION;
        end else if (idx == `TPG_IDX_FIRST_DIR) begin
            sel = TPG_SEL_FIRST_DIR;
        end else if (idx == `TPG_IDX_SECOND_DIR
                     || idx == `TPG_IDX_SECOND_DIR_M) begin
            sel = TPG_SEL_SECOND_DIR;
        end else if (idx == `TPG_IDX_THIRD_DIR) begin
            sel = TPG_SEL_THIRD_DIR;
        end else if (idx == `TPG_IDX_ANALOG_CFG) begin
            sel = TPG_SEL_ANALOG_CFG;
        end else begin
            sel = TPG_SEL_NONE;
        end
    end

    // ==========================================================
    // Analog pin map of the first port
    // ==========================================================
    function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
        logic [5:0] m;
        m = 6'h00;
        case (cfg)
            3'h0, 3'h1: m = 6'h2F;
            3'h2, 3'h3: m = 6'h0F;
            3'h4, 3'h5: m = 6'h0B;
            default: m = 6'h00;
        endcase
        return m;
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    tpg_state_t q;
    tpg_state_t d;

    logic [7:0] rd_byte;
    logic setup;
    logic access;
    logic wr;
    logic refresh;
    logic [3:0] chg_diff;
    logic mismatch;
    logic ext_edge;
    logic [7:0] third_dir_eff;

    // Read data mux
    always_comb begin
        rd_byte = 8'h00;
        case (sel)
            TPG_SEL_FIRST_DATA: begin
                // Analog pins read as zero
                rd_byte = {2'h0, first_s & ~analog_mask(q.analog_cfg)};
            end
            TPG_SEL_SECOND_DATA: rd_byte = second_s;
            TPG_SEL_THIRD_DATA: rd_byte = third_s;
            TPG_SEL_INTC: rd_byte = q.intc;
            TPG_SEL_OPTION: rd_byte = q.option;
            TPG_SEL_FIRST_DIR: rd_byte = {2'h0, q.first_dir};
            TPG_SEL_SECOND_DIR: rd_byte = q.second_dir;
            TPG_SEL_THIRD_DIR: rd_byte = q.third_dir;
            TPG_SEL_ANALOG_CFG: rd_byte = {5'h00, q.analog_cfg};
            default: rd_byte = 8'h00;
        endcase
    end

    assign setup = psel & ~penable;
    assign access = psel & penable & q.pready;
    assign wr = access & pwrite & (sel != TPG_SEL_NONE);
    assign refresh = access & (sel == TPG_SEL_SECOND_DATA);

    // Input pins 7..4 only
    assign chg_diff = (second_s[7:4] ^ q.chg_ref) & q.second_dir[7:4];
    assign mismatch = |chg_diff & ~refresh;

    // Rising when edge select is 1, falling when 0
    assign ext_edge = q.option[`TPG_OPT_EDGE_SEL]
                      ? (second_s[0] & ~q.ext_prev)
                      : (~second_s[0] & q.ext_prev);

    assign third_dir_eff = (periph_en & periph_dir) | (~periph_en & q.third_dir);

    always_comb begin
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        if (setup) begin
            d.pready = 1'b1;
            d.pslverr = (sel == TPG_SEL_NONE);
            d.prdata = {24'h000000, rd_byte};
        end
        if (wr) begin
            case (sel)
                TPG_SEL_FIRST_DATA: d.first_lat = pwdata[5:0];
                TPG_SEL_SECOND_DATA: d.second_lat = pwdata[7:0];
                TPG_SEL_THIRD_DATA: d.third_lat = pwdata[7:0];
                TPG_SEL_INTC: d.intc = pwdata[7:0];
                TPG_SEL_OPTION: d.option = pwdata[7:0];
                TPG_SEL_FIRST_DIR: d.first_dir = pwdata[5:0];
                TPG_SEL_SECOND_DIR: d.second_dir = pwdata[7:0];
                TPG_SEL_THIRD_DIR: d.third_dir = pwdata[7:0];
                TPG_SEL_ANALOG_CFG: d.analog_cfg = pwdata[2:0];
                default: d.option = q.option;
            endcase
        end
        if (refresh) begin
            d.chg_ref = second_s[7:4];
        end
        // Hardware set wins over a software clear
        if (mismatch) begin
            d.intc[`TPG_INTC_CHG_FLAG] = 1'b1;
        end
        if (ext_edge) begin
            d.intc[`TPG_INTC_EXT_FLAG] = 1'b1;
        end
        d.ext_prev = second_s[0];
        d.wake = (q.intc[`TPG_INTC_CHG_FLAG] & q.intc[`TPG_INTC_CHG_EN])
                 | (q.intc[`TPG_INTC_EXT_FLAG] & q.intc[`TPG_INTC_EXT_EN]);

        // First port; bit 4 is open drain
        d.first_out = q.first_lat;
        d.first_oe = ~q.first_dir;
        d.first_out[`TPG_OPEN_DRAIN_BIT] = 1'b0;
        d.first_oe[`TPG_OPEN_DRAIN_BIT] = ~q.first_dir[`TPG_OPEN_DRAIN_BIT]
                                          & ~q.first_lat[`TPG_OPEN_DRAIN_BIT];

        d.second_out = q.second_lat;
        d.second_oe = ~q.second_dir;
        d.second_pullup = {8{~q.option[`TPG_OPT_PULLUP_N]}} & q.second_dir;

        d.third_out = (periph_en & periph_out) | (~periph_en & q.third_lat);
        d.third_oe = ~third_dir_eff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.option <= `TPG_RST_OPTION;
            q.first_dir <= `TPG_RST_FIRST_DIR;
            q.second_dir <= `TPG_RST_DIR8;
            q.third_dir <= `TPG_RST_DIR8;
            q.first_lat <= 6'h00;
            q.second_lat <= 8'h00;
            q.third_lat <= 8'h00;
            q.analog_cfg <= `TPG_RST_ANALOG_CFG;
            q.intc <= `TPG_RST_INTC;
            q.chg_ref <= 4'h0;
            q.ext_prev <= 1'b0;
            q.first_out <= 6'h00;
            q.first_oe <= 6'h00;
            q.second_out <= 8'h00;
            q.second_oe <= 8'h00;
            q.second_pullup <= 8'h00;
            q.third_out <= 8'h00;
            q.third_oe <= 8'h00;
            q.prdata <= 32'h00000000;
            q.pready <= 1'b0;
            q.pslverr <= 1'b0;
            q.wake <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign first_port_out = q.first_out;
    assign first_port_oe = q.first_oe;
    assign second_port_out = q.second_out;
    assign second_port_oe = q.second_oe;
    assign second_port_pullup = q.second_pullup;
    assign third_port_out = q.third_out;
    assign third_port_oe = q.third_oe;
    assign analog_config_field = q.analog_cfg;
    assign wake_req = q.wake;

endmodule

`default_nettype wire

// ===== test/tpg_top_sva.sv
// Concurrent checks on the ports of the three-port GPIO top.
// Assumes the tpg_top port names and the register index macros.
`timescale 1ns/1ps
`default_nettype none
`include "tpg_regs.svh"

// ==========
// Checker
module tpg_top_sva #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] second_port_oe,
    input wire logic [7:0] second_port_pullup,
    input wire logic [7:0] third_port_oe,
    input wire logic [7:0] third_port_out,
    input wire logic [7:0] periph_en,
    input wire logic [7:0] periph_dir,
    input wire logic [7:0] periph_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pready && pwrite;
    wire logic rd = psel && penable && pready && !pwrite;
    function automatic logic at(input logic [ADDR_W-1:0] a, input logic [9:0] i);
        return a == {i, 2'h0};
    endfunction
    dir2_drive_a: assert property (wr && at(paddr, `TPG_IDX_SECOND_DIR) |->
        ##2 second_port_oe == ~$past(pwdata[7:0], 2)) else $error("second oe wrong");
    dir3_drive_a: assert property (wr && at(paddr, `TPG_IDX_THIRD_DIR) |-> ##2
        ($past(periph_en) != 8'h00 || third_port_oe == ~$past(pwdata[7:0], 2)))
        else $error("third oe wrong");
    pull_off_a: assert property ((second_port_oe & second_port_pullup) == 8'h00)
        else $error("pull-up on an output");
    pull_write_a: assert property (wr && at(paddr, `TPG_IDX_OPTION) |-> ##2
        second_port_pullup == ({8{~$past(pwdata[7], 2)}} & ~second_port_oe))
        else $error("pull-up wrong");
    pull_reset_a: assert property ($rose(presetn) |->
        (second_port_pullup == 8'h00)[*3]) else $error("pull-up on after reset");
    periph_ovr_a: assert property ($past(presetn) |->
        ((((third_port_oe ^ ~$past(periph_dir)) | ((third_port_out ^ $past(periph_out))
        & ~$past(periph_dir))) & $past(periph_en)) == 8'h00)) else $error("override wrong");
    ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one pulse");
    unmapped_err_a: assert property (psel && !penable && at(paddr, 10'h000) |=>
        pslverr && prdata == 32'h0) else $error("unmapped not refused");
    upper_zero_a: assert property (rd && at(paddr, `TPG_IDX_FIRST_DIR) |->
        prdata[31:6] == 26'h0) else $error("unimplemented bits set");
    cover property (wr && at(paddr, `TPG_IDX_OPTION));
    cover property (rd && pslverr);
    cover property (periph_en != 8'h00);
endmodule

bind tpg_top tpg_top_sva #(.ADDR_W(ADDR_W)) tpg_top_sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .second_port_oe(second_port_oe), .second_port_pullup(second_port_pullup),
    .third_port_oe(third_port_oe), .third_port_out(third_port_out),
    .periph_en(periph_en), .periph_dir(periph_dir), .periph_out(periph_out));
`default_nettype wire

// ===== test/tpg_pin_model.sv
// Eight external pins: device drive, board drive, weak pull-up.
// Assumes one pclk; released lines with no board drive and no pull-up toggle every cycle.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Pin levels
module tpg_pin_model (
    input wire logic pclk,
    input wire logic [7:0] oe,
    input wire logic [7:0] out,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] drv_en,
    input wire logic [7:0] drv_val,
    output logic [7:0] pin
);
    logic [7:0] float_q = 8'h00;
    always @(posedge pclk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe[i])
                pin[i] = out[i];
            else if (drv_en[i])
                pin[i] = drv_val[i];
            else if (pull_en[i])
                pin[i] = 1'h1;
            else
                pin[i] = float_q[i];
        end
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench: APB register sequences on the three-port GPIO.
// Assumes tpg_top, tpg_pin_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tpg_regs.svh"

module testbench;
    localparam logic [9:0] idx_opt = `TPG_IDX_OPTION;
    localparam logic [9:0] idx_intc = `TPG_IDX_INTC;
    localparam logic [9:0] idx_d2 = `TPG_IDX_SECOND_DATA;
    localparam logic [9:0] idx_t2 = `TPG_IDX_SECOND_DIR;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, wake_req, err_q;
    logic [7:0] periph_en = 8'h00, periph_dir = 8'h00, periph_out = 8'h00;
    logic [7:0] drv2 = 8'h00, en2 = 8'hFF, drv3 = 8'h00;
    logic [7:0] pin1, pin2, pin3, out2, oe2, pu2, out3, oe3;
    logic [5:0] out1, oe1;
    logic [2:0] acfg;
    int miscompares = 0;
    int check_count = 0;
    always #4 pclk = ~pclk;

    tpg_top tpg_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_port_in(pin1[5:0]), .first_port_out(out1), .first_port_oe(oe1),
        .second_port_in(pin2), .second_port_out(out2), .second_port_oe(oe2),
        .second_port_pullup(pu2), .third_port_in(pin3), .third_port_out(out3),
        .third_port_oe(oe3), .periph_en(periph_en), .periph_dir(periph_dir),
        .periph_out(periph_out), .analog_config_field(acfg), .wake_req(wake_req));
    tpg_pin_model first_pins_i (.pclk(pclk), .oe({2'h0, oe1}), .out({2'h0, out1}),
        .pull_en(8'h00), .drv_en(8'hFF), .drv_val(8'h3F), .pin(pin1));
    tpg_pin_model second_pins_i (.pclk(pclk), .oe(oe2), .out(out2), .pull_en(pu2),
        .drv_en(en2), .drv_val(drv2), .pin(pin2));
    tpg_pin_model third_pins_i (.pclk(pclk), .oe(oe3), .out(out3), .pull_en(8'h00),
        .drv_en(8'hFF), .drv_val(drv3), .pin(pin3));

    // ==========
    // Tasks
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rdata = prdata;
        err_q = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        apb(1'h1, idx, wd);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
        apb(1'h0, idx, 8'h00);
        chk($sformatf("register %h", idx), exp, rdata[7:0]);
    endtask
    task automatic look(input int n);
        repeat (n) @(negedge pclk);
    endtask
    task automatic drive(input logic [7:0] d, e, pe, pd, po);
        @(posedge pclk);
        drv2 <= d;
        en2 <= e;
        periph_en <= pe;
        periph_dir <= pd;
        periph_out <= po;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        finish_test();
    end

    // ==========
    // Sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        rdchk(idx_opt, 8'hFF);
        rdchk(`TPG_IDX_FIRST_DIR, 8'h3F);
        rdchk(idx_t2, 8'hFF);
        rdchk(`TPG_IDX_ANALOG_CFG, 8'h00);
        rdchk(`TPG_IDX_FIRST_DATA, 8'h10);
        rdchk(10'h000, 8'h00);
        chk("slave error", 8'h01, {7'h0, err_q});
        wr(`TPG_IDX_SECOND_DATA_M, 8'h5A);
        wr(`TPG_IDX_SECOND_DIR_M, 8'h0F);
        look(2);
        chk("second oe", 8'hF0, oe2);
        chk("second out", 8'h50, out2 & oe2);
        wr(idx_opt, 8'h7F);
        drive(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        look(4);
        chk("pull-up", 8'h0F, pu2);
        rdchk(idx_d2, 8'h5F);
        // Change flag polled in the control register and seen on wake_req
        wr(idx_t2, 8'hF0);
        drive(8'h00, 8'hFF, 8'h00, 8'h00, 8'h00);
        look(3);
        rdchk(idx_d2, 8'h0A);
        wr(idx_intc, 8'h08);
        wr(idx_t2, 8'hE0);
        look(5);
        rdchk(idx_intc, 8'h08);
        drive(8'h20, 8'hFF, 8'h00, 8'h00, 8'h00);
        look(5);
        rdchk(idx_intc, 8'h09);
        look(1);
        chk("wake", 8'h01, {7'h0, wake_req});
        wr(idx_intc, 8'h08);
        rdchk(idx_intc, 8'h09);
        rdchk(idx_d2, 8'h3A);
        wr(idx_intc, 8'h08);
        rdchk(idx_intc, 8'h08);
        look(1);
        chk("wake", 8'h00, {7'h0, wake_req});
        wr(idx_t2, 8'hE1);
        for (int es = 0; es < 2; es++) begin
            wr(idx_opt, {1'h1, es[0], 6'h3F});
            drive({7'h10, ~es[0]}, 8'hFF, 8'h00, 8'h00, 8'h00);
            look(4);
            wr(idx_intc, 8'h10);
            drive({7'h10, es[0]}, 8'hFF, 8'h00, 8'h00, 8'h00);
            look(4);
            rdchk(idx_intc, 8'h12);
            wr(idx_intc, 8'h10);
            drive({7'h10, ~es[0]}, 8'hFF, 8'h00, 8'h00, 8'h00);
            look(4);
            rdchk(idx_intc, 8'h10);
        end
        wr(`TPG_IDX_THIRD_DIR, 8'h0F);
        wr(`TPG_IDX_THIRD_DATA, 8'hA5);
        look(2);
        chk("third oe", 8'hF0, oe3);
        chk("third out", 8'hA0, out3 & oe3);
        drive(8'h20, 8'hFF, 8'h03, 8'h01, 8'h02);
        look(2);
        chk("override oe", 8'hF2, oe3);
        chk("override out", 8'hA2, out3 & oe3);
        wr(`TPG_IDX_THIRD_DIR, 8'hFF);
        look(2);
        chk("override oe", 8'h02, oe3);
        @(posedge pclk);
        drv3 <= 8'h5C;
        look(3);
        rdchk(`TPG_IDX_THIRD_DATA, 8'h5E);
        wr(`TPG_IDX_ANALOG_CFG, 8'h04);
        look(2);
        chk("analog field", 8'h04, {5'h0, acfg});
        rdchk(`TPG_IDX_FIRST_DATA, 8'h34);
        wr(`TPG_IDX_ANALOG_CFG, 8'hFE);
        rdchk(`TPG_IDX_ANALOG_CFG, 8'h06);
        rdchk(`TPG_IDX_FIRST_DATA, 8'h3F);
        // First port drive; bit 4 only pulls low
        wr(`TPG_IDX_FIRST_DIR, 8'h00);
        wr(`TPG_IDX_FIRST_DATA, 8'h3F);
        look(2);
        chk("first oe", 8'h2F, {2'h0, oe1});
        chk("first out", 8'h2F, {2'h0, out1});
        finish_test();
    end
endmodule
`default_nettype wire
